/* timer_three_defines.vh */
// Register map, field positions and reset values of the 16-bit timer/counter
`ifndef TIMER_THREE_DEFINES_VH
`define TIMER_THREE_DEFINES_VH

`define ADDR_W 4
`define ADDR_CONTROL 4'h0
`define ADDR_COUNT_LOW 4'h1
`define ADDR_COUNT_HIGH 4'h2
`define ADDR_IRQ_STATUS 4'h3
`define ADDR_IRQ_MASK 4'h4

`define CONTROL_RESET 8'h00
`define BIT_TIMER_RUN 0
`define BIT_WIDE_ACCESS 1
`define BIT_SYNC_DISABLE 2
`define BIT_OSC_ENABLE 3
`define PRESCALE_LSB 4
`define CLKSEL_LSB 6

`define CLKSEL_INSTR 2'h0
`define CLKSEL_SYSTEM 2'h1
`define CLKSEL_EXTERNAL 2'h2

`define PRESCALE_1 2'h0
`define PRESCALE_2 2'h1
`define PRESCALE_4 2'h2
`define PRESCALE_8 2'h3

`define INSTR_DIVIDE 2'h3
`define BIT_IRQ_OVERFLOW 0

`endif

/* edge_sync.v */
// Two-stage synchroniser with rising-edge detect on the synchronised level
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Asynchronous level in
  input wire asyncIn,
  // Synchronised level and rising-edge pulse
  output wire syncOut,
  output wire riseOut
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign syncOut = sync_q;
  assign riseOut = sync_q & ~last_q;

endmodule

`default_nettype wire

/* timer_three.v */
// 16-bit timer/counter with selectable clock source, prescaler and overflow interrupt
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer_three_defines.vh"

// What this block does
// - Sixteen-bit up-counter, clocked internally as timer or externally as counter.
// - Count is visible as separately readable and writable high and low bytes.
// - Clock select 00 instruction clock, 01 system clock, 10 external source.
// - External source with oscillator disabled counts rising edges of count pin.
// - External source with oscillator enabled uses crystal or digital aux pin.
// - Prescale field divides the input clock by 1, 2, 4 or 8.
// - Oscillator enable bit turns on the secondary oscillator for this timer.
// - Sync bit 0 synchronises external clock; 1 selects a separate two-flop path with the same timing.
// - With an internal source the sync bit is ignored.
// - Wide access bit makes both count bytes transfer as one operation.
// - Capture/compare special event trigger resets the counter.
// - Control register also supplies clock selection to capture/compare units.
module timer_three (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register port
  input wire [`ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // External clock sources
  input wire extCountClockPin,
  input wire digitalAuxClockPin,
  input wire secondaryOscillator,
  input wire auxOscModeConfig,
  // Capture/compare link
  input wire specialEventTrigger,
  output wire [1:0] captureClockSelect,
  output wire secondaryOscEnable,
  // Interrupt
  output wire timerIrq
);

  wire selExt;
  wire selSys;
  wire [1:0] clkSel;
  wire [1:0] prescaleSel;
  wire extRaw;
  wire extSyncLevel;
  wire extSyncRise;
  wire extTick;
  wire inputTick;
  wire prescaleTick;
  wire countStep;
  wire [15:0] countInc;
  wire overflowEvent;

  reg [7:0] control_q;
  reg [15:0] count_q;
  reg [15:0] count_d;
  reg [7:0] highBuffer_q;
  reg [7:0] highBuffer_d;
  reg [1:0] instrDiv_q;
  reg [2:0] prescale_q;
  reg prescaleHit;
  reg extRawLast_q;
  reg extRawMeta_q;
  reg extRawDly_q;
  reg [0:0] irqStatus_q;
  reg [0:0] irqMask_q;

  // Divider terminal mask for each prescale code
  function [2:0] prescaleMask;
    input [1:0] code;
    begin
      case (code)
        `PRESCALE_2: prescaleMask = 3'h1;
        `PRESCALE_4: prescaleMask = 3'h3;
        `PRESCALE_8: prescaleMask = 3'h7;
        default: prescaleMask = 3'h0;
      endcase
    end
  endfunction

  assign clkSel = control_q[`CLKSEL_LSB+1:`CLKSEL_LSB];
  assign prescaleSel = control_q[`PRESCALE_LSB+1:`PRESCALE_LSB];
  assign selExt = (clkSel == `CLKSEL_EXTERNAL);
  assign selSys = (clkSel == `CLKSEL_SYSTEM);
  assign secondaryOscEnable = control_q[`BIT_OSC_ENABLE];
  assign captureClockSelect = clkSel;

  // Pick the external source: pin, crystal or digital aux input
  assign extRaw = !control_q[`BIT_OSC_ENABLE] ? extCountClockPin :
                  (auxOscModeConfig ? digitalAuxClockPin : secondaryOscillator);

  edge_sync extSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .asyncIn(extRaw),
    .syncOut(extSyncLevel),
    .riseOut(extSyncRise)
  );

  // Unsynchronised path still needs two flops to sample safely on one clock;
  // it keeps the edge-qualifying stage too, so its timing matches edge_sync.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      extRawMeta_q <= 1'b0;
      extRawDly_q <= 1'b0;
      extRawLast_q <= 1'b0;
    end
    else
    begin
      extRawMeta_q <= extRaw;
      extRawDly_q <= extRawMeta_q;
      extRawLast_q <= extRawDly_q;
    end
  end

  assign extTick = control_q[`BIT_SYNC_DISABLE] ?
                   (extRawDly_q & ~extRawLast_q) : extSyncRise;

  // Instruction clock is the system clock divided by four
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      instrDiv_q <= 2'h0;
    else
      instrDiv_q <= instrDiv_q + 2'h1;
  end

  // Sync bit only matters on the external path
  assign inputTick = selExt ? extTick :
                     selSys ? 1'b1 : (instrDiv_q == `INSTR_DIVIDE);

  always @*
  begin
    prescaleHit = inputTick && ((prescale_q & prescaleMask(prescaleSel)) ==
                  prescaleMask(prescaleSel));
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      prescale_q <= 3'h0;
    else if (regWrite && (regAddr == `ADDR_CONTROL))
      prescale_q <= 3'h0;
    else if (inputTick && control_q[`BIT_TIMER_RUN])
      prescale_q <= prescale_q + 3'h1;
  end

  assign prescaleTick = prescaleHit;
  assign countStep = prescaleTick && control_q[`BIT_TIMER_RUN];
  assign countInc = count_q + 16'h0001;
  assign overflowEvent = countStep && (count_q == 16'hffff) && !specialEventTrigger;

  // Count update: software write, trigger reset, then counting
  always @*
  begin
    count_d = count_q;
    highBuffer_d = highBuffer_q;
    if (countStep)
      count_d = countInc;
    if (specialEventTrigger)
      count_d = 16'h0000;
    if (regWrite && (regAddr == `ADDR_COUNT_HIGH))
    begin
      if (control_q[`BIT_WIDE_ACCESS])
        highBuffer_d = regWrData;
      else
        count_d[15:8] = regWrData;
    end
    if (regWrite && (regAddr == `ADDR_COUNT_LOW))
    begin
      count_d[7:0] = regWrData;
      if (control_q[`BIT_WIDE_ACCESS])
        count_d[15:8] = highBuffer_q;
    end
    // Wide read latches the high byte with the low byte
    if (regRead && (regAddr == `ADDR_COUNT_LOW) && control_q[`BIT_WIDE_ACCESS])
      highBuffer_d = count_q[15:8];
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_q <= 16'h0000;
      highBuffer_q <= 8'h00;
    end
    else
    begin
      count_q <= count_d;
      highBuffer_q <= highBuffer_d;
    end
  end

  // Control and mask registers
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      control_q <= `CONTROL_RESET;
      irqMask_q <= 1'b0;
    end
    else if (regWrite)
    begin
      if (regAddr == `ADDR_CONTROL)
        control_q <= regWrData;
      if (regAddr == `ADDR_IRQ_MASK)
        irqMask_q <= regWrData[`BIT_IRQ_OVERFLOW];
    end
  end

  // Sticky overflow flag, cleared by reading status; a new overflow wins
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      irqStatus_q <= 1'b0;
    else if (overflowEvent)
      irqStatus_q <= 1'b1;
    else if (regRead && (regAddr == `ADDR_IRQ_STATUS))
      irqStatus_q <= 1'b0;
  end

  assign timerIrq = |(irqStatus_q & irqMask_q);

  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        `ADDR_CONTROL: regRdData <= control_q;
        `ADDR_COUNT_LOW: regRdData <= count_q[7:0];
        `ADDR_COUNT_HIGH: regRdData <= control_q[`BIT_WIDE_ACCESS] ?
                                       highBuffer_q : count_q[15:8];
        `ADDR_IRQ_STATUS: regRdData <= {7'h00, irqStatus_q};
        `ADDR_IRQ_MASK: regRdData <= {7'h00, irqMask_q};
        default: regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

  // Selecting the system clock for capture/compare use is left to software
  // the hardware does not block it.

endmodule

`default_nettype wire

/* timer_three_assertions.sv */
// Port-level assertions for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_three_defines.vh"
module timer_three_assertions (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register port
  input wire [`ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  // Capture/compare link and interrupt
  input wire specialEventTrigger,
  input wire [1:0] captureClockSelect,
  input wire secondaryOscEnable,
  input wire timerIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire ctlWr = regWrite && regAddr == `ADDR_CONTROL;
  a_read_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero when idle");
  a_ctl_write_out: assert property (ctlWr |=>
    captureClockSelect == $past(regWrData[7:6]) && secondaryOscEnable == $past(regWrData[3]))
    else $error("control outputs not loaded");
  a_ctl_out_stable: assert property (
    $changed({captureClockSelect, secondaryOscEnable}) |-> $past(ctlWr))
    else $error("control outputs moved without write");
  a_ctl_read_back: assert property (regRead && regAddr == `ADDR_CONTROL |=>
    regRdData[7:6] == $past(captureClockSelect) && regRdData[3] == $past(secondaryOscEnable))
    else $error("control read back wrong");
  a_mask_off_quiet: assert property (
    regWrite && regAddr == `ADDR_IRQ_MASK && !regWrData[0] |=> !timerIrq)
    else $error("masked interrupt still high");
  a_unmapped_zero: assert property (regRead && regAddr > `ADDR_IRQ_MASK |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_trig_clears: assert property ($past(specialEventTrigger) && specialEventTrigger &&
    !$past(regWrite) && regRead && regAddr == `ADDR_COUNT_LOW |=> regRdData == 8'h00)
    else $error("count not cleared by trigger");
  a_trig_no_irq: assert property ($past(specialEventTrigger) &&
    $past(specialEventTrigger, 2) && !$past(regWrite) |-> !$rose(timerIrq))
    else $error("overflow while trigger held");
  c_irq: cover property ($rose(timerIrq));
  c_trig_read: cover property (specialEventTrigger && regRead);
  c_ctl_then_read: cover property (ctlWr ##1 regRead);
endmodule
bind timer_three timer_three_assertions chk (.ref_clk, .rst_b, .regAddr, .regWrData, .regWrite,
  .regRead, .regRdData, .specialEventTrigger, .captureClockSelect, .secondaryOscEnable, .timerIrq);
`default_nettype wire

/* ext_clock_source.sv */
// Far-side clock sources: count pin, crystal and digital aux pin
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
  // Reference timing
  input wire logic ref_clk,
  // Clocks seen by the timer
  output logic extCountClockPin,
  output logic secondaryOscillator,
  output logic digitalAuxClockPin
);
  logic [3:0] tick_q = 4'h0;
  // Skewed off the edge so pin changes never race the timer's sampling
  always @(posedge ref_clk) tick_q <= #3 tick_q + 4'h1;
  assign extCountClockPin = tick_q[2];
  assign secondaryOscillator = tick_q[3];
  assign digitalAuxClockPin = tick_q[1];
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_three_defines.vh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic specialEventTrigger = 1'b0;
  logic auxOscModeConfig = 1'b0;
  wire [7:0] regRdData;
  wire [1:0] captureClockSelect;
  wire secondaryOscEnable, timerIrq, extCountClockPin, secondaryOscillator, digitalAuxClockPin;
  logic [7:0] v0;
  logic [7:0] v1;
  logic [7:0] ctl [12] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'hc1, 8'h05, 8'h40, 8'h81,
    8'h85, 8'h89, 8'h89};
  logic [7:0] dif [12] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h08, 8'h08, 8'h08, 8'h00, 8'h04,
    8'h04, 8'h02, 8'h08};
  int fails = 0;
  int checks = 0;
  always #5 ref_clk = ~ref_clk;
  ext_clock_source src (.ref_clk, .extCountClockPin, .secondaryOscillator, .digitalAuxClockPin);
  timer_three dut (.ref_clk, .rst_b, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .extCountClockPin, .digitalAuxClockPin, .secondaryOscillator, .auxOscModeConfig,
    .specialEventTrigger, .captureClockSelect, .secondaryOscEnable, .timerIrq);
  // Write strobe stays up so back-to-back writes never touch it twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regRead <= 1'b0;
    regWrite <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    regAddr <= a;
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(`ADDR_CONTROL, v0);
    cmp(v0, `CONTROL_RESET);
    rd(4'h7, v0);
    cmp(v0, 8'h00);
    wr(`ADDR_COUNT_LOW, 8'h34);
    wr(`ADDR_COUNT_HIGH, 8'h12);
    rd(`ADDR_COUNT_LOW, v0);
    rd(`ADDR_COUNT_HIGH, v1);
    cmp({v1[3:0], v0[3:0]}, 8'h24);
    cmp(v0, 8'h34);
    cmp(v1, 8'h12);
    wr(`ADDR_CONTROL, 8'h02);
    wr(`ADDR_COUNT_HIGH, 8'h77);
    rd(`ADDR_COUNT_LOW, v0);
    rd(`ADDR_COUNT_HIGH, v1);
    cmp(v1, 8'h12);
    // The low-byte read above refilled the shared high buffer, so load it again
    wr(`ADDR_COUNT_HIGH, 8'h77);
    wr(`ADDR_COUNT_LOW, 8'h11);
    rd(`ADDR_COUNT_LOW, v0);
    rd(`ADDR_COUNT_HIGH, v1);
    cmp(v1 ^ v0, 8'h66);
    cmp(v1, 8'h77);
    for (int i = 0; i < 12; i++)
    begin
      auxOscModeConfig <= (i == 11);
      wr(`ADDR_CONTROL, ctl[i]);
      idle(8);
      rd(`ADDR_COUNT_LOW, v0);
      idle(31);
      rd(`ADDR_COUNT_LOW, v1);
      cmp(v1 - v0, dif[i]);
    end
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_COUNT_LOW, 8'hfe);
    wr(`ADDR_COUNT_HIGH, 8'hff);
    wr(`ADDR_IRQ_MASK, 8'h00);
    wr(`ADDR_CONTROL, 8'h41);
    idle(6);
    wr(`ADDR_CONTROL, 8'h40);
    idle(2);
    cmp({7'h0, timerIrq}, 8'h00);
    wr(`ADDR_IRQ_MASK, 8'h01);
    idle(2);
    cmp({7'h0, timerIrq}, 8'h01);
    rd(`ADDR_IRQ_STATUS, v0);
    rd(`ADDR_IRQ_STATUS, v1);
    cmp({v0[3:0], v1[3:0]}, 8'h10);
    cmp({7'h0, timerIrq}, 8'h00);
    wr(`ADDR_CONTROL, 8'h41);
    idle(4);
    specialEventTrigger <= 1'b1;
    idle(3);
    rd(`ADDR_COUNT_LOW, v0);
    specialEventTrigger <= 1'b0;
    cmp(v0, 8'h00);
    wr(`ADDR_CONTROL, 8'h89);
    idle(2);
    // Capture/compare use keeps away from the system clock source
    cmp({captureClockSelect, 5'h0, secondaryOscEnable}, 8'h81);
    report_and_stop;
  end
  initial
  begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule
`default_nettype wire
